/* rtl/srp_defines.svh */
`ifndef SRP_DEFINES_SVH
`define SRP_DEFINES_SVH

// ----------------------------------------
// frame layout
// ----------------------------------------
`define SRP_CMD_BIT 5'd7
`define SRP_LAST_BIT 5'd23
`define SRP_REG_COUNT 12
`define SRP_POL_BIT 9

// ----------------------------------------
// wait timing, oscillator cycles per count
// ----------------------------------------
`define SRP_WAIT_UNIT 8192

// ----------------------------------------
// register slots in map order
// ----------------------------------------
`define SRP_IX_TSP 0
`define SRP_IX_PWM 1
`define SRP_IX_PPT 2
`define SRP_IX_AEW 3
`define SRP_IX_APK 4
`define SRP_IX_AMC 5
`define SRP_IX_ASC 6
`define SRP_IX_BEW 7
`define SRP_IX_BPK 8
`define SRP_IX_BMC 9
`define SRP_IX_BSC 10
`define SRP_IX_DCM 11

// ----------------------------------------
// per slot: offset, reset, field masks per event
// ----------------------------------------
`define SRP_OFS_LIST {6'h0b, 6'h20, 6'h21, 6'h22, 6'h23, 6'h24, \
    6'h25, 6'h27, 6'h28, 6'h29, 6'h2a, 6'h2c}
`define SRP_RST_LIST {16'h0000, 16'h000a, 16'h0000, 16'h0003, 16'h0000, 16'h0000, \
    16'h0000, 16'h0003, 16'h0000, 16'h0000, 16'h0000, 16'h0000}
`define SRP_MCS_LIST {16'h0298, 16'h0000, 16'h009f, 16'h0000, 16'h0000, 16'h0800, \
    16'h0000, 16'h0000, 16'h0000, 16'h0800, 16'h0000, 16'h0007}
`define SRP_MVD_LIST {16'h0000, 16'h00ff, 16'h0000, 16'h0000, 16'h0000, 16'h0000, \
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000}
`define SRP_MDT1_LIST {16'h0000, 16'h7f00, 16'h0000, 16'h00ff, 16'hffff, 16'h0000, \
    16'h0000, 16'h00ff, 16'hffff, 16'h0000, 16'h0000, 16'h0000}
`define SRP_MA_LIST {16'h0000, 16'h0000, 16'h0000, 16'h3f00, 16'h0000, 16'h33ff, \
    16'hffff, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000}
`define SRP_MB_LIST {16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, \
    16'h0000, 16'h3f00, 16'h0000, 16'h33ff, 16'hffff, 16'h0000}
`define SRP_MENA_LIST {16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0400, \
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000}
`define SRP_MENB_LIST {16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, \
    16'h0000, 16'h0000, 16'h0000, 16'h0400, 16'h0000, 16'h0000}

`endif

/* rtl/srp_pkg.sv */
// ----------------------------------------
// shared types
// ----------------------------------------
package srp_pkg;
    // one register word
    typedef logic [15:0] srp_word_t;
    // register slot number
    typedef logic [3:0] srp_idx_t;
    // what the current 24-bit group is doing
    typedef enum {SRP_ADDR, SRP_WRITE, SRP_READ} srp_phase_t;
endpackage

/* rtl/srp_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// two-flop synchroniser, one lane per pin
// ----------------------------------------
module srp_sync #(
    parameter int W = 5
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    // first stage feeds only the second
    logic [W-1:0] meta_reg;

    for (genvar b = 0; b < W; b++) begin : g_lane
        // per-bit pair of flops
        always_ff @(posedge clk_sys) begin
            if (reset) begin
                meta_reg[b] <= 1'b0;
                sync_out[b] <= 1'b0;
            end else begin
                meta_reg[b] <= async_in[b];
                sync_out[b] <= meta_reg[b];
            end
        end
    end
endmodule // srp_sync
`default_nettype wire

/* rtl/srp_wait_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// wait timer: count times unit cycles
// ----------------------------------------
module srp_wait_timer #(
    parameter int UNIT = 8192
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic start,
    input wire logic [7:0] count,
    output logic busy,
    output logic done
);
    // last prescaler value of one unit
    localparam logic [15:0] PRE_LAST = 16'(UNIT - 1);

    logic [15:0] pre_reg; // cycles inside one unit
    logic [7:0] cnt_reg; // units still to go

    // a fresh start restarts the wait from scratch
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pre_reg <= 16'h0000;
            cnt_reg <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
        end else if (start) begin
            // zero length ends at once
            pre_reg <= 16'h0000;
            cnt_reg <= count;
            busy <= (count != 8'h00);
            done <= (count == 8'h00);
        end else if (busy && pre_reg == PRE_LAST) begin
            // one unit elapsed
            pre_reg <= 16'h0000;
            cnt_reg <= cnt_reg - 8'h01;
            busy <= (cnt_reg != 8'h01);
            done <= (cnt_reg == 8'h01);
        end else begin
            pre_reg <= busy ? pre_reg + 16'h0001 : 16'h0000;
            done <= 1'b0;
        end
    end
endmodule // srp_wait_timer
`default_nettype wire

/* rtl/srp_top.sv */
`include "srp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Functional notes
// R1: select high opens, select low closes
// R2: 24-bit set: address, command, spare, data
// R3: bits LSB first: A0-A5, C, spare, D0-D15
// R4: command 0 writes, 1 reads
// R5: input sampled on serial clock rise
// R6: output floats when deselected, else 0
// R7: port logic held reset while deselected
// R8: write lands at closing select edge
// R9: short write of 23 bits discarded
// R10: long write: each full group writes
// R11: read shifts register out LSB first
// R12: host keeps oscillator running during writes
// R13: hard reset clears port and registers
// R14: fields apply at their own events
// R15: enable rises at wait end, falls excite
// R16: host writes during start wait interval
// R17: timing follows polarity adjusted sync rise
// R18: polarity bit 1 selects falling edge
// R19: polarity toggle counts as sync edge
// R20: dc register: source bit2, bridge bits1-0
// R21: zero start wait blocks all transfers; the code still makes the select-close ones
// R22: start wait lasts count times 8192
// R23: pending shadow copied to active on event
// ----------------------------------------
module srp_top #(
    // oscillator cycles per wait count unit
    parameter int WAIT_UNIT = `SRP_WAIT_UNIT
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic hard_reset_n,
    input wire logic chip_select,
    input wire logic serial_clk,
    input wire logic serial_in,
    input wire logic focus_zoom_vsync,
    output logic serial_out,
    output logic serial_out_oe,
    output logic [15:0] test_and_sync_polarity_cfg,
    output logic [15:0] pwm_and_start_wait_cfg,
    output logic [15:0] pulse_pin_test_cfg,
    output logic [15:0] alpha_phase_and_excite_wait,
    output logic [15:0] alpha_peak_widths,
    output logic [15:0] alpha_motion_ctrl,
    output logic [15:0] alpha_step_cycle,
    output logic [15:0] beta_phase_and_excite_wait,
    output logic [15:0] beta_peak_widths,
    output logic [15:0] beta_motion_ctrl,
    output logic [15:0] beta_step_cycle,
    output logic [15:0] dc_motor_input_ctrl,
    output logic start_wait_busy,
    output logic alpha_excite_busy,
    output logic beta_excite_busy
);
    // ----------------------------------------
    // register map tables
    // ----------------------------------------
    localparam int N = `SRP_REG_COUNT;
    localparam logic [0:N-1][5:0] OFS = `SRP_OFS_LIST;
    localparam logic [0:N-1][15:0] RST = `SRP_RST_LIST;
    localparam logic [0:N-1][15:0] MCS = `SRP_MCS_LIST;
    localparam logic [0:N-1][15:0] MVD = `SRP_MVD_LIST;
    localparam logic [0:N-1][15:0] MDT1 = `SRP_MDT1_LIST;
    localparam logic [0:N-1][15:0] MA = `SRP_MA_LIST;
    localparam logic [0:N-1][15:0] MB = `SRP_MB_LIST;
    localparam logic [0:N-1][15:0] MENA = `SRP_MENA_LIST;
    localparam logic [0:N-1][15:0] MENB = `SRP_MENB_LIST;
    // bits that hold a field; the rest read zero
    localparam logic [0:N-1][15:0] WMASK = MCS | MVD | MDT1 | MA | MB | MENA | MENB;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [4:0] pin_s; // synchronised pins
    srp_sync #(.W(5)) u_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .async_in({hard_reset_n, focus_zoom_vsync, serial_in, serial_clk, chip_select}),
        .sync_out(pin_s)
    );
    wire cs_s = pin_s[0];
    wire sclk_s = pin_s[1];
    wire sin_s = pin_s[2];
    wire vd_s = pin_s[3];
    wire hrn_s = pin_s[4];

    // hard reset pin wipes everything after the synchronisers, like the system reset
    wire rst_all = reset | ~hrn_s; // see R13

    // ----------------------------------------
    // edge detection on sampled pins
    // ----------------------------------------
    logic cs_prev_reg; // select one cycle ago
    logic sclk_prev_reg; // serial clock one cycle ago
    logic vs_prev_reg; // adjusted sync one cycle ago
    logic apply_cs_reg; // select closed last cycle
    logic [15:0] act_reg [0:N-1]; // active settings
    logic [15:0] sh_reg [0:N-1]; // pending shadows

    // polarity xor: a polarity flip on a steady sync makes an edge
    wire pol = act_reg[`SRP_IX_TSP][`SRP_POL_BIT]; // see R18
    wire vs_int = vd_s ^ pol; // see R17
    wire vd_edge = vs_int & ~vs_prev_reg; // see R19
    wire sclk_rise = cs_s & sclk_s & ~sclk_prev_reg; // see R5
    wire ev_cs = cs_prev_reg & ~cs_s; // see R1

    // previous values of the sampled levels
    always_ff @(posedge clk_sys) begin
        if (rst_all) begin
            cs_prev_reg <= 1'b0;
            sclk_prev_reg <= 1'b0;
            vs_prev_reg <= 1'b0;
            apply_cs_reg <= 1'b0;
        end else begin
            cs_prev_reg <= cs_s;
            sclk_prev_reg <= sclk_s;
            vs_prev_reg <= vs_int;
            apply_cs_reg <= ev_cs;
        end
    end

    // ----------------------------------------
    // serial shifter and address decode
    // ----------------------------------------
    logic [4:0] bit_cnt_reg; // bit in current group
    logic [23:0] shift_reg; // received bits, LSB first
    logic [15:0] rd_shift_reg; // read data still to send
    srp_pkg::srp_phase_t phase_reg; // group phase

    // new bits enter at the top, so A0 ends at bit 0
    wire [23:0] shift_next = {sin_s, shift_reg[23:1]}; // see R3
    wire at_cmd = (bit_cnt_reg == `SRP_CMD_BIT);
    wire at_last = (bit_cnt_reg == `SRP_LAST_BIT);
    // address is decoded twice: for a read and at group end
    wire [5:0] addr_sel = at_cmd ? shift_next[21:16] : shift_next[5:0];
    wire cmd_read = shift_next[22]; // see R4

    logic [N-1:0] hit; // address match per slot
    for (genvar i = 0; i < N; i++) begin : g_hit
        assign hit[i] = (addr_sel == OFS[i]);
    end

    // slot number of the matching address
    function automatic srp_pkg::srp_idx_t enc(input logic [N-1:0] h);
        srp_pkg::srp_idx_t r;
        r = 4'h0;
        for (int k = 0; k < N; k++) begin
            if (h[k]) begin
                r = 4'(k);
            end
        end
        return r;
    endfunction

    wire addr_hit = |hit;
    wire srp_pkg::srp_idx_t idx_sel = enc(hit);
    // unmapped addresses read as zero
    wire [15:0] rd_word = addr_hit ? sh_reg[idx_sel] : 16'h0000;

    // shifter; any low select parks it in reset
    always_ff @(posedge clk_sys) begin
        if (rst_all || !cs_s) begin // see R7
            bit_cnt_reg <= 5'd0;
            shift_reg <= 24'h000000;
            phase_reg <= srp_pkg::SRP_ADDR;
        end else if (sclk_rise) begin
            shift_reg <= shift_next;
            bit_cnt_reg <= at_last ? 5'd0 : bit_cnt_reg + 5'd1; // see R2
            unique case (phase_reg)
                srp_pkg::SRP_ADDR: begin
                    if (at_cmd) begin
                        phase_reg <= cmd_read ? srp_pkg::SRP_READ : srp_pkg::SRP_WRITE; // see R4
                    end
                end
                srp_pkg::SRP_WRITE, srp_pkg::SRP_READ: begin
                    if (at_last) begin
                        phase_reg <= srp_pkg::SRP_ADDR;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // read data output
    // ----------------------------------------
    wire rd_start = sclk_rise & at_cmd & cmd_read & (phase_reg == srp_pkg::SRP_ADDR);
    wire rd_step = sclk_rise & (phase_reg == srp_pkg::SRP_READ);

    // data bits on the input are ignored while reading
    always_ff @(posedge clk_sys) begin
        if (rst_all || !cs_s) begin
            serial_out <= 1'b0;
            rd_shift_reg <= 16'h0000;
        end else if (rd_start) begin
            serial_out <= rd_word[0]; // see R11
            rd_shift_reg <= {1'b0, rd_word[15:1]};
        end else if (rd_step) begin
            // drop to 0 once D15 has been sent
            serial_out <= at_last ? 1'b0 : rd_shift_reg[0]; // see R11
            rd_shift_reg <= {1'b0, rd_shift_reg[15:1]};
        end
    end

    // float while deselected; the pad driver resolves the level
    assign serial_out_oe = cs_s; // see R6

    // ----------------------------------------
    // pending write, one group behind
    // ----------------------------------------
    logic pend_vld_reg; // a full group waits
    srp_pkg::srp_idx_t pend_idx_reg; // its slot
    logic [15:0] pend_data_reg; // its data

    // the newest full group waits for the next group or select
    // close, so a short tail never disturbs it
    wire grp_done = sclk_rise & at_last & (phase_reg == srp_pkg::SRP_WRITE); // see R10
    wire commit_vld = pend_vld_reg & (grp_done | ev_cs); // see R8

    // holding register for the last complete group
    always_ff @(posedge clk_sys) begin
        if (rst_all || !cs_s) begin // see R9
            pend_vld_reg <= 1'b0;
            pend_idx_reg <= 4'h0;
            pend_data_reg <= 16'h0000;
        end else if (grp_done) begin
            // unmapped groups are dropped here
            pend_vld_reg <= addr_hit;
            pend_idx_reg <= idx_sel;
            pend_data_reg <= shift_next[23:8];
        end
    end

    // ----------------------------------------
    // reflection events
    // ----------------------------------------
    logic dt1_done; // start wait over
    logic a_done; // alpha excitation wait over
    logic b_done; // beta excitation wait over
    wire [7:0] dt1_sh = sh_reg[`SRP_IX_PWM][7:0];
    // a zero count freezes every transfer but the select-close one
    wire vd_go = vd_edge & (dt1_sh != 8'h00); // see R21

    // start wait, armed by the adjusted sync edge
    srp_wait_timer #(.UNIT(WAIT_UNIT)) u_start (
        .clk_sys(clk_sys),
        .reset(rst_all),
        .start(vd_go),
        .count(dt1_sh),
        .busy(start_wait_busy),
        .done(dt1_done)
    ); // see R22

    // alpha excitation wait follows the start wait
    srp_wait_timer #(.UNIT(WAIT_UNIT)) u_alpha (
        .clk_sys(clk_sys),
        .reset(rst_all),
        .start(dt1_done),
        .count(sh_reg[`SRP_IX_AEW][7:0]),
        .busy(alpha_excite_busy),
        .done(a_done)
    );

    // beta excitation wait follows the start wait
    srp_wait_timer #(.UNIT(WAIT_UNIT)) u_beta (
        .clk_sys(clk_sys),
        .reset(rst_all),
        .start(dt1_done),
        .count(sh_reg[`SRP_IX_BEW][7:0]),
        .busy(beta_excite_busy),
        .done(b_done)
    );

    // copy masked bits of the shadow when the event fires
    function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n,
                                         input logic [15:0] m, input logic e);
        return e ? ((o & ~m) | (n & m)) : o;
    endfunction

    // ----------------------------------------
    // shadow and active registers
    // ----------------------------------------
    for (genvar i = 0; i < N; i++) begin : g_reg
        // enable: ones move at start wait end, zeros at excite end
        wire [15:0] m_dt1 = MDT1[i] | ((MENA[i] | MENB[i]) & sh_reg[i]); // see R15
        wire [15:0] m_a = MA[i] | (MENA[i] & ~sh_reg[i]); // see R15
        wire [15:0] m_b = MB[i] | (MENB[i] & ~sh_reg[i]);
        // cs uses the delayed pulse so the commit has landed
        wire [15:0] s1 = merge(act_reg[i], sh_reg[i], MCS[i], apply_cs_reg); // see R14
        wire [15:0] s2 = merge(s1, sh_reg[i], MVD[i], vd_go); // see R14
        wire [15:0] s3 = merge(s2, sh_reg[i], m_dt1, dt1_done); // see R14
        wire [15:0] s4 = merge(s3, sh_reg[i], m_a, a_done);
        wire [15:0] act_next = merge(s4, sh_reg[i], m_b, b_done); // see R23

        // serial port writes shadow; events move it on
        always_ff @(posedge clk_sys) begin
            if (rst_all) begin // see R13
                sh_reg[i] <= RST[i];
                act_reg[i] <= RST[i];
            end else begin
                if (commit_vld && pend_idx_reg == 4'(i)) begin
                    sh_reg[i] <= pend_data_reg & WMASK[i]; // see R20
                end
                act_reg[i] <= act_next;
            end
        end
    end

    // ----------------------------------------
    // active settings out
    // ----------------------------------------
    assign test_and_sync_polarity_cfg = act_reg[`SRP_IX_TSP];
    assign pwm_and_start_wait_cfg = act_reg[`SRP_IX_PWM];
    assign pulse_pin_test_cfg = act_reg[`SRP_IX_PPT];
    assign alpha_phase_and_excite_wait = act_reg[`SRP_IX_AEW];
    assign alpha_peak_widths = act_reg[`SRP_IX_APK];
    assign alpha_motion_ctrl = act_reg[`SRP_IX_AMC];
    assign alpha_step_cycle = act_reg[`SRP_IX_ASC];
    assign beta_phase_and_excite_wait = act_reg[`SRP_IX_BEW];
    assign beta_peak_widths = act_reg[`SRP_IX_BPK];
    assign beta_motion_ctrl = act_reg[`SRP_IX_BMC];
    assign beta_step_cycle = act_reg[`SRP_IX_BSC];
    assign dc_motor_input_ctrl = act_reg[`SRP_IX_DCM];

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst_all);

    // close of select with a full group commits it
    sequence s_close_full;
        ev_cs && pend_vld_reg;
    endsequence

    property p_cs_resets;
        !cs_s |=> (bit_cnt_reg == 5'd0) && (phase_reg == srp_pkg::SRP_ADDR);
    endproperty
    a_cs_resets: assert property (p_cs_resets) else $error("port not held in reset"); // see R7

    property p_float;
        !cs_s |-> !serial_out_oe;
    endproperty
    a_float: assert property (p_float) else $error("output driven while deselected"); // see R6

    property p_out_zero;
        serial_out_oe && serial_out |-> phase_reg == srp_pkg::SRP_READ;
    endproperty
    a_out_zero: assert property (p_out_zero) else $error("output high outside read"); // see R6

    property p_commit_close;
        s_close_full |-> commit_vld ##1 !pend_vld_reg;
    endproperty
    a_commit_close: assert property (p_commit_close) else $error("write lost at close"); // see R8

    property p_short_drop;
        ev_cs && !pend_vld_reg |-> !commit_vld;
    endproperty
    a_short_drop: assert property (p_short_drop) else $error("short write committed"); // see R9

    property p_group_chain;
        grp_done && pend_vld_reg |-> commit_vld;
    endproperty
    a_group_chain: assert property (p_group_chain) else $error("earlier group lost"); // see R10

    property p_zero_wait;
        vd_edge && dt1_sh == 8'h00 |=> !start_wait_busy || $past(start_wait_busy);
    endproperty
    a_zero_wait: assert property (p_zero_wait) else $error("zero wait started"); // see R21

    property p_wait_len;
        vd_go && (WAIT_UNIT * dt1_sh >= 8) |=> start_wait_busy [*8];
    endproperty
    a_wait_len: assert property (p_wait_len) else $error("start wait ended early"); // see R22

    property p_sync_edge;
        vd_edge && !$past(rst_all) |-> (!pol && $rose(vd_s)) || (pol && $fell(vd_s)) || $changed(pol);
    endproperty
    a_sync_edge: assert property (p_sync_edge) else $error("bad sync edge"); // see R18

    property p_enable_up;
        dt1_done && sh_reg[`SRP_IX_AMC][10] |=> act_reg[`SRP_IX_AMC][10];
    endproperty
    a_enable_up: assert property (p_enable_up) else $error("enable not raised"); // see R15

    property p_read_bit;
        rd_step && !at_last |=> serial_out == $past(rd_shift_reg[0]);
    endproperty
    a_read_bit: assert property (p_read_bit) else $error("read bit wrong"); // see R11
endmodule // srp_top
`default_nettype wire

/* dv/srp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// host side serial master, behavioural
// ----------------------------------------
module srp_host_model (
    input wire logic clk_sys,
    input wire logic serial_out,
    output logic chip_select,
    output logic serial_clk,
    output logic serial_in
);
    // clock rests low between frames
    initial begin
        chip_select = 1'b0;
        serial_clk = 1'b0;
        serial_in = 1'b0;
    end

    // one select window of n bits, lsb first; read bits captured before each rise
    task automatic send(input logic [63:0] v, input int n, output logic [15:0] q);
        q = 16'h0000;
        @(negedge clk_sys);
        chip_select = 1'b1;
        repeat (4) @(negedge clk_sys);
        for (int i = 0; i < n; i++) begin
            serial_in = v[i];
            repeat (4) @(negedge clk_sys);
            if (i >= 8 && i < 24) begin
                q[i-8] = serial_out;
            end
            serial_clk = 1'b1;
            repeat (4) @(negedge clk_sys);
            serial_clk = 1'b0;
        end
        repeat (4) @(negedge clk_sys);
        chip_select = 1'b0;
        // released data line must not look like the last bit
        serial_in = ~serial_in;
        repeat (6) @(negedge clk_sys);
    endtask
endmodule // srp_host_model
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic hard_reset_n = 1'b1;
    logic vsync = 1'b0;
    logic cs, sck, sdi, sdo, oe, swb, aeb, beb;
    logic [15:0] tsp, pwm, ppt, aew, apk, amc, asc, bew, bpk, bmc, bsc, dcm;
    logic [15:0] q;
    int mismatches = 0;
    int n_tests = 0;
    int n;

    // oscillator never stops, capture depends on it
    always #10 clk_sys = ~clk_sys;

    srp_top #(.WAIT_UNIT(4)) u_srp_top (.clk_sys(clk_sys), .reset(reset), .hard_reset_n(hard_reset_n),
        .chip_select(cs), .serial_clk(sck), .serial_in(sdi), .focus_zoom_vsync(vsync), .serial_out(sdo),
        .serial_out_oe(oe), .test_and_sync_polarity_cfg(tsp), .pwm_and_start_wait_cfg(pwm),
        .pulse_pin_test_cfg(ppt), .alpha_phase_and_excite_wait(aew), .alpha_peak_widths(apk),
        .alpha_motion_ctrl(amc), .alpha_step_cycle(asc), .beta_phase_and_excite_wait(bew),
        .beta_peak_widths(bpk), .beta_motion_ctrl(bmc), .beta_step_cycle(bsc), .dc_motor_input_ctrl(dcm),
        .start_wait_busy(swb), .alpha_excite_busy(aeb), .beta_excite_busy(beb));
    srp_host_model u_srp_host_model (.clk_sys(clk_sys), .serial_out(sdo), .chip_select(cs),
        .serial_clk(sck), .serial_in(sdi));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic tally_and_finish();
        if (mismatches == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        u_srp_host_model.send({40'h0, d, 2'b00, a}, 24, q);
        repeat (3) @(negedge clk_sys);
    endtask

    // bounded wait on the start wait flag, n counts cycles spent
    task automatic wait_busy(input logic v);
        n = 0;
        while (swb !== v) begin
            @(negedge clk_sys);
            n++;
            if (n > 200) begin
                mismatches++;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, swb, v);
                tally_and_finish();
            end
        end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_write_read();
        wr(6'h2c, 16'h0005);
        chk(dcm, 16'h0005);
        u_srp_host_model.send({40'h0, 16'h0000, 2'b01, 6'h2c}, 24, q);
        chk(q, 16'h0005);
        u_srp_host_model.send({40'h0, 16'hffff, 2'b01, 6'h3f}, 24, q);
        chk(q, 16'h0000);
        u_srp_host_model.send({40'h0, 16'h0002, 2'b00, 6'h2c}, 23, q);
        repeat (3) @(negedge clk_sys);
        chk(dcm, 16'h0005);
        u_srp_host_model.send({11'h0, 5'h1f, 16'h0002, 2'b00, 6'h2c, 16'h0081, 2'b00, 6'h21}, 53, q);
        repeat (3) @(negedge clk_sys);
        chk(ppt, 16'h0081);
        chk(dcm, 16'h0002);
    endtask

    task automatic t_events();
        wr(6'h20, 16'h1f00);
        vsync = 1'b1;
        repeat (10) @(negedge clk_sys);
        chk({swb, pwm[14:0]}, 16'h000a);
        vsync = 1'b0;
        wr(6'h20, 16'h1f02);
        wr(6'h24, 16'h0400);
        vsync = 1'b1;
        wait_busy(1'b1);
        @(negedge clk_sys);
        chk(pwm, 16'h0002);
        wait_busy(1'b0);
        chk({15'h0, n >= 6 && n <= 8}, 16'h0001);
        @(negedge clk_sys);
        chk(pwm, 16'h1f02);
        chk(amc, 16'h0400);
        chk({14'h0, aeb, beb}, 16'h0003);
        repeat (30) @(negedge clk_sys);
        vsync = 1'b0;
        repeat (6) @(negedge clk_sys);
        wr(6'h0b, 16'h0200);
        chk(tsp, 16'h0200);
        wait_busy(1'b1);
    endtask

    // long start wait, motion settings written inside it
    task automatic t_in_wait();
        wr(6'h20, 16'h1f40);
        vsync = 1'b1;
        repeat (4) @(negedge clk_sys);
        vsync = 1'b0;
        wait_busy(1'b1);
        wr(6'h24, 16'h0165);
        chk({swb, amc[14:0]}, 16'h8400);
        wait_busy(1'b0);
        @(negedge clk_sys);
        chk(amc, 16'h0400);
        repeat (14) @(negedge clk_sys);
        chk(amc, 16'h0165);
    endtask

    task automatic t_hard_reset();
        hard_reset_n = 1'b0;
        repeat (5) @(negedge clk_sys);
        chk(dcm | ppt | tsp, 16'h0000);
        chk(pwm, 16'h000a);
        hard_reset_n = 1'b1;
    endtask

    initial begin
        repeat (12) @(negedge clk_sys);
        reset = 1'b0;
        repeat (6) @(negedge clk_sys);
        chk(pwm, 16'h000a);
        chk(aew & bew, 16'h0003);
        chk({15'h0, oe}, 16'h0000);
        chk(apk | amc | asc | bpk | bmc | bsc | dcm | ppt | tsp, 16'h0000);
        t_write_read();
        t_events();
        t_in_wait();
        t_hard_reset();
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
